/* File: verif/eagc_chk_sva.sv */
// Purpose: port-level checks of the alarm generation control block
// Assumes: clk_en held high by the bench
// Notes:   channel 0 watched; the other channels share the logic
`timescale 1ns/10ps

module eagc_chk #(
  parameter int unsigned CRC_LOSS_CYC = 20
) (
  // clock, reset
  input wire logic                   mclk,
  input wire logic                   reset_n,
  // apb
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic                   pready,
  input wire logic                   pslverr,
  // receive side
  input wire logic [7:0]             rx_fas_lost,
  input wire logic [7:0]             rx_crc_mf_lost,
  input wire logic [7:0]             frame_loss_defect,
  input wire logic [7:0]             frame_search_req,
  input wire logic [7:0]             align_algo_sel,
  // transmit side
  input wire eagc_pkg::eagc_tx_in_t  tx_in [eagc_pkg::CHANNELS],
  input wire eagc_pkg::eagc_tx_out_t tx_out [eagc_pkg::CHANNELS]
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // run length of crc loss, so a search pulse can be tied to its cause
  int unsigned crc_run_r;
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n) crc_run_r <= 0;
    else crc_run_r <= rx_crc_mf_lost[0] ? crc_run_r + 1 : 0;

  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no answer after setup");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("answer longer than one cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error flag without answer");
  property p_fas; rx_fas_lost[0] |=> frame_loss_defect[0]; endproperty
  a_fas: assert property (p_fas) else $error("fas loss not declared");
  property p_clr; !rx_fas_lost[0] && !rx_crc_mf_lost[0] |=> !frame_loss_defect[0]; endproperty
  a_clr: assert property (p_clr) else $error("frame loss without cause");
  property p_srch; frame_search_req[0] |-> crc_run_r >= CRC_LOSS_CYC; endproperty
  a_srch: assert property (p_srch) else $error("search before loss time");
  property p_sone; frame_search_req[0] |=> !frame_search_req[0]; endproperty
  a_sone: assert property (p_sone) else $error("search pulse too long");
  property p_alg; !(psel && penable && pwrite) |=> $stable(align_algo_sel); endproperty
  a_alg: assert property (p_alg) else $error("algorithm select moved");
  property p_txz; !tx_in[0].valid |=> !tx_out[0].valid && !tx_out[0].data; endproperty
  a_txz: assert property (p_txz) else $error("bit sent on idle slot");
endmodule

bind eagc_top eagc_chk #(.CRC_LOSS_CYC(CRC_LOSS_CYC)) u_chk (
  .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .rx_fas_lost(rx_fas_lost),
  .rx_crc_mf_lost(rx_crc_mf_lost), .frame_loss_defect(frame_loss_defect),
  .frame_search_req(frame_search_req), .align_algo_sel(align_algo_sel),
  .tx_in(tx_in), .tx_out(tx_out));

/* File: verif/eagc_far_end.sv */
// Purpose: far-end frame timing source feeding the transmit stream
// Assumes: one bit per mclk unless stalled
// Notes:   stalls freeze the frame position
`timescale 1ns/10ps

module eagc_far_end (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic             gap,
  output eagc_pkg::eagc_tx_in_t tx_in [eagc_pkg::CHANNELS]
);
  logic [11:0] pos_r;
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n) pos_r <= 12'h000;
    else if (!gap) pos_r <= pos_r + 12'h001;
  // data mixes bit 7 in so the TS16 multiframe yellow slot carries a zero that insertion must flip; TS0 yellow is zero in every other non-FAS frame
  always_comb
    for (int i = 0; i < eagc_pkg::CHANNELS; i++) begin
      tx_in[i].valid     = !gap;
      tx_in[i].data      = pos_r[0] ^ pos_r[5] ^ pos_r[7] ^ pos_r[9];
      tx_in[i].fas_frame = !pos_r[8];
      tx_in[i].ts        = pos_r[7:3];
      tx_in[i].bit_idx   = pos_r[2:0];
      tx_in[i].mf_frame  = pos_r[11:8];
    end
endmodule

/* File: verif/tb_top.sv */
// Purpose: self-checking bench for eagc_top
// Assumes: short crc loss count of 20 cycles
// Notes:   transmit bits of channel 0 checked every cycle
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end

module tb_top;
  logic mclk = 0, reset_n = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic gap = 0, rnd_on = 0, pready, pslverr, irq, err, exp_d = 0, loss_q = 0, alt_q = 1;
  logic exp_v = 0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, rd, prdata, lfsr = 32'h59CB6919;
  logic [7:0] rx_fas_lost = 0, rx_crc_mf_lost = 0, rx_cas_mf_lost = 0, ctl = 0, v [8];
  logic [7:0] frame_loss_defect, frame_search_req, align_algo_sel;
  eagc_pkg::eagc_tx_in_t  tx_in [eagc_pkg::CHANNELS];
  eagc_pkg::eagc_tx_out_t tx_out [eagc_pkg::CHANNELS];
  int err_count = 0, n_compared = 0, cyc = 0, pulses = 0;

  eagc_top #(.CRC_LOSS_CYC(20)) DUT (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .rx_fas_lost(rx_fas_lost),
    .rx_crc_mf_lost(rx_crc_mf_lost), .rx_cas_mf_lost(rx_cas_mf_lost),
    .frame_loss_defect(frame_loss_defect), .frame_search_req(frame_search_req),
    .align_algo_sel(align_algo_sel), .tx_in(tx_in), .tx_out(tx_out), .irq(irq));
  eagc_far_end u_far (.mclk(mclk), .reset_n(reset_n), .gap(gap), .tx_in(tx_in));

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic exp_bit(input eagc_pkg::eagc_tx_in_t t, input logic [7:0] c,
                                   input logic a, input logic l, input logic cs);
    logic f, au, y0, y1;
    f  = c[5:4] == 2'b11;
    au = c[5:4] == 2'b01;
    y0 = t.ts == 5'h00 && t.bit_idx == 3'h2 && !t.fas_frame;
    y1 = t.ts == 5'h10 && t.bit_idx == 3'h5 && t.mf_frame == 4'h0;
    if (!t.valid) return 1'b0;
    if (c[7]) return a;
    if ((y0 && (f || au && l)) || (y1 && (f || au && cs))) return 1'b1;
    return t.data;
  endfunction

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    if (w && a == 16'h0108) ctl <= d[7:0];
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  initial forever #12.5 mclk = ~mclk;

  // reference model of the channel 0 transmit bit, one cycle behind
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 50000) begin err_count++; print_verdict(); end
    if (frame_search_req[0] === 1'b1) pulses++;
    if (reset_n) `CHK({tx_out[0].valid, tx_out[0].data}, {exp_v, exp_d})
    exp_d  <= reset_n ? exp_bit(tx_in[0], ctl, alt_q, loss_q, rx_cas_mf_lost[0]) : 1'b0;
    exp_v  <= reset_n & tx_in[0].valid;
    loss_q <= reset_n & (rx_fas_lost[0] | (~ctl[6] & rx_crc_mf_lost[0]));
    alt_q  <= !reset_n || !ctl[7] ? 1'b1 : (tx_in[0].valid ? ~alt_q : alt_q);
    if (rnd_on) begin
      lfsr <= nxt(lfsr);
      gap <= lfsr[2:0] == 3'h0;
      rx_fas_lost <= lfsr[15:8];
      rx_crc_mf_lost <= lfsr[31:24];
      rx_cas_mf_lost <= lfsr[23:16];
    end
  end

  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      apb(0, {c[3:0], 12'h108}, 32'h0);
      `CHK(rd, 32'h0)
      v[c] = lfsr[7:0] ^ (8'h35 * c[7:0]);
      apb(1, {c[3:0], 12'h108}, {24'hFFFFFF, v[c]});
    end
    for (int c = 0; c < 8; c++) begin apb(0, {c[3:0], 12'h108}, 32'h0); `CHK(rd, {24'h0, v[c]}) end
    apb(1, 16'h8108, 32'hFF);
    `CHK(err, 1'b1)
    apb(0, 16'h0100, 32'h0);
    `CHK(err, 1'b1)
    apb(1, 16'h510C, 32'h1);
    repeat (2) @(posedge mclk);
    `CHK(align_algo_sel, 8'h20)
    apb(1, 16'h510C, 32'h0);
    repeat (2) @(posedge mclk);
    `CHK(align_algo_sel, 8'h00)
    $display("test registers done");
    apb(1, 16'h0108, 32'h40);
    apb(1, 16'h0114, 32'h3);
    apb(1, 16'h0110, 32'h3);
    pulses = 0;
    rx_crc_mf_lost <= 8'h01;
    repeat (30) @(posedge mclk);
    `CHK(frame_loss_defect[0], 1'b0)
    repeat (15) @(posedge mclk);
    rx_crc_mf_lost <= 8'h00;
    repeat (3) @(posedge mclk);
    `CHK(pulses, 2)
    `CHK(irq, 1'b1)
    apb(0, 16'h0110, 32'h0);
    `CHK(rd, 32'h2)
    apb(1, 16'h0110, 32'h2);
    repeat (3) @(posedge mclk);
    `CHK(irq, 1'b0)
    apb(1, 16'h0108, 32'h0);
    rx_crc_mf_lost <= 8'h01;
    repeat (3) @(posedge mclk);
    `CHK(frame_loss_defect[0], 1'b1)
    rx_crc_mf_lost <= 8'h00;
    rx_fas_lost <= 8'hFF;
    repeat (3) @(posedge mclk);
    `CHK(frame_loss_defect, 8'hFF)
    apb(0, 16'h0118, 32'h0);
    `CHK(rd, 32'h3)
    rx_fas_lost <= 8'h00;
    $display("test receive done");
    rnd_on <= 1'b1;
    for (int m = 0; m < 8; m++) begin
      apb(1, 16'h0108, {24'h0, m[2], lfsr[6], m[1:0], lfsr[3:0]});
      repeat (4200) @(posedge mclk);
    end
    rnd_on <= 1'b0;
    $display("test transmit done");
    print_verdict();
  end
endmodule

/* File: verilog/eagc_pkg.sv */
// Purpose: shared constants and carriers for the E1 alarm generation control block
// Assumes: 40 MHz mclk, eight framer channels, APB register access
// Notes:   byte offsets are per channel; channel n sits at n * CH_STRIDE
package eagc_pkg;

  // ****************************************************************
  // sizes and timing
  // ****************************************************************
  localparam int          CHANNELS      = 8;
  localparam int          CLK_KHZ       = 40000;
  localparam int          CRC_LOSS_MS   = 8;
  localparam int          CRC_LOSS_CYC  = CRC_LOSS_MS * CLK_KHZ;
  localparam int          TMR_W         = 19;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [15:0] CH_STRIDE     = 16'h1000;
  localparam logic [11:0] OFS_AGC       = 12'h108;
  localparam logic [11:0] OFS_ALIGN     = 12'h10C;
  localparam logic [11:0] OFS_IRQ_STS   = 12'h110;
  localparam logic [11:0] OFS_IRQ_MASK  = 12'h114;
  localparam logic [11:0] OFS_STATE     = 12'h118;
  localparam logic [7:0]  AGC_RESET     = 8'h00;
  localparam logic        ALIGN_RESET   = 1'b0;
  localparam logic [1:0]  IRQ_RESET     = 2'h0;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int          AGC_ALT_BIT   = 7;
  localparam int          AGC_CRIT_BIT  = 6;
  localparam int          AGC_YEL_HI    = 5;
  localparam int          AGC_YEL_LO    = 4;
  localparam int          ALIGN_SEL_BIT = 0;
  localparam int          EV_LOSS_BIT   = 0;
  localparam int          EV_SEARCH_BIT = 1;

  // ****************************************************************
  // frame positions; bits numbered 1..8 on the line, index 0 is bit 1
  // ****************************************************************
  localparam logic [4:0]  TS_FAS        = 5'h00;
  localparam logic [4:0]  TS_CAS        = 5'h10;
  localparam logic [2:0]  YEL_BIT_IDX   = 3'h2;
  localparam logic [2:0]  MFYEL_BIT_IDX = 3'h5;
  localparam logic [3:0]  MF_FRAME0     = 4'h0;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    EAGC_YEL_OFF   = 2'b00,
    EAGC_YEL_AUTO  = 2'b01,
    EAGC_YEL_OFF2  = 2'b10,
    EAGC_YEL_FORCE = 2'b11
  } eagc_yel_mode_t;

  typedef struct packed {
    logic       valid;
    logic       data;
    logic       fas_frame;
    logic [4:0] ts;
    logic [2:0] bit_idx;
    logic [3:0] mf_frame;
  } eagc_tx_in_t;

  typedef struct packed {
    logic valid;
    logic data;
  } eagc_tx_out_t;

endpackage

/* File: verilog/eagc_top.sv */
// Purpose: per-channel E1 alarm generation control, frame loss criteria, test pattern
// Assumes: receive defect inputs and transmit bit stream run on mclk
// Notes:   registers over APB, one level interrupt output
//
// Functional notes
// - alignment algorithm select 0 picks search algorithm one, 1 picks algorithm two
// - pattern bit 7 set sends unframed repeating 1010 instead of traffic
// - criteria bit clear: frame loss on CRC multiframe loss or FAS loss
// - criteria bit set: frame loss on FAS loss; CRC loss over 8ms forces search
// - yellow field 00 or 10 sends no yellow and no multiframe yellow
// - yellow field 01: TS0 bit 3 of non-FAS frames high during frame loss
// - yellow field 01: TS16 bit 6 of frame 0 high during CAS multiframe loss
// - yellow field 11 forces both yellow indicators to one
`timescale 1ns/10ps

// ****************************************************************
// one channel: control copy, loss criteria, alarm insertion
// ****************************************************************
module eagc_chan #(
  parameter int unsigned CRC_LOSS_CYC = eagc_pkg::CRC_LOSS_CYC
) (
  // clock, reset, enable
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  input  wire logic                  clk_en,
  // register writes aimed at this channel
  input  wire logic                  wr_agc,
  input  wire logic                  wr_align,
  input  wire logic                  wr_sts,
  input  wire logic                  wr_mask,
  input  wire logic [31:0]           pwdata,
  // receive defects
  input  wire logic                  fas_lost,
  input  wire logic                  crc_mf_lost,
  input  wire logic                  cas_mf_lost,
  // transmit stream
  input  wire eagc_pkg::eagc_tx_in_t tx_in,
  output eagc_pkg::eagc_tx_out_t     tx_out,
  // register and receive state
  output logic [7:0]                 agc,
  output logic                       align,
  output logic [1:0]                 sts,
  output logic [1:0]                 mask,
  output logic                       frame_loss,
  output logic                       search_req,
  output logic                       irq_hit
);

  localparam int            TW      = eagc_pkg::TMR_W;
  localparam logic [TW-1:0] TMR_END = TW'(CRC_LOSS_CYC - 1);

  logic [7:0]             agc_r;
  logic                   align_r;
  logic [1:0]             sts_r;
  logic [1:0]             mask_r;
  logic                   fl_r;
  logic                   fl_prev_r;
  logic                   fs_r;
  logic [TW-1:0]          tmr_r;
  logic                   alt_r;
  eagc_pkg::eagc_tx_out_t txo_r;

  wire        crit     = agc_r[eagc_pkg::AGC_CRIT_BIT];
  wire        alt_en   = agc_r[eagc_pkg::AGC_ALT_BIT];
  wire  [1:0] yel_fld  = agc_r[eagc_pkg::AGC_YEL_HI:eagc_pkg::AGC_YEL_LO];
  wire        yel_auto = (yel_fld == eagc_pkg::EAGC_YEL_AUTO);
  wire        yel_frc  = (yel_fld == eagc_pkg::EAGC_YEL_FORCE);

  // loss declaration by criteria
  wire        fl_nxt   = crit ? fas_lost
                              : (fas_lost || crc_mf_lost);
  // timer restarts after each pulse, so a long loss repeats the search
  wire        tmr_run  = crit && crc_mf_lost;
  wire        tmr_end  = tmr_run && (tmr_r == TMR_END);

  // yellow insertion; 00 and 10 leave both indicators alone
  wire        yel_on   = yel_frc || (yel_auto && fl_r);
  wire        mfy_on   = yel_frc || (yel_auto && cas_mf_lost);
  wire        at_yel   = !tx_in.fas_frame && (tx_in.ts == eagc_pkg::TS_FAS)
                         && (tx_in.bit_idx == eagc_pkg::YEL_BIT_IDX);
  wire        at_mfy   = (tx_in.ts == eagc_pkg::TS_CAS)
                         && (tx_in.mf_frame == eagc_pkg::MF_FRAME0)
                         && (tx_in.bit_idx == eagc_pkg::MFYEL_BIT_IDX);
  wire        tx_bit   = alt_en ? alt_r :
                         ((at_yel && yel_on) || (at_mfy && mfy_on)) ? 1'b1 :
                         tx_in.data;

  // events: frame loss onset, forced search
  wire  [1:0] ev       = {fs_r, fl_r && !fl_prev_r};
  wire  [1:0] w1c      = wr_sts ? pwdata[1:0] : 2'h0;

  // control registers, one copy per channel
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      agc_r   <= eagc_pkg::AGC_RESET;
      align_r <= eagc_pkg::ALIGN_RESET;
      mask_r  <= eagc_pkg::IRQ_RESET;
    end else if (clk_en) begin
      if (wr_agc) begin
        agc_r <= pwdata[7:0];
      end
      if (wr_align) begin
        align_r <= pwdata[eagc_pkg::ALIGN_SEL_BIT];
      end
      if (wr_mask) begin
        mask_r <= pwdata[1:0];
      end
    end
  end

  // receive side state
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      fl_r      <= 1'b0;
      fl_prev_r <= 1'b0;
      fs_r      <= 1'b0;
      tmr_r     <= '0;
    end else if (clk_en) begin
      fl_r      <= fl_nxt;
      fl_prev_r <= fl_r;
      fs_r      <= tmr_end;
      tmr_r     <= (!tmr_run || tmr_end) ? '0 : tmr_r + 1'b1;
    end
  end

  // status: a new event beats a same-cycle clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sts_r <= eagc_pkg::IRQ_RESET;
    end else if (clk_en) begin
      sts_r <= (sts_r & ~w1c) | ev;
    end
  end

  // transmit path; pattern restarts high when enabled
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      alt_r <= 1'b1;
      txo_r <= '0;
    end else if (clk_en) begin
      if (!alt_en) begin
        alt_r <= 1'b1;
      end else if (tx_in.valid) begin
        alt_r <= !alt_r;
      end
      txo_r.valid <= tx_in.valid;
      txo_r.data  <= tx_in.valid ? tx_bit : 1'b0;
    end
  end

  assign agc        = agc_r;
  assign align      = align_r;
  assign sts        = sts_r;
  assign mask       = mask_r;
  assign frame_loss = fl_r;
  assign search_req = fs_r;
  assign tx_out     = txo_r;
  assign irq_hit    = |(sts_r & mask_r);

endmodule

module eagc_top #(
  parameter int unsigned CRC_LOSS_CYC = eagc_pkg::CRC_LOSS_CYC
) (
  // clock, reset, enable
  input  wire logic                   mclk,
  input  wire logic                   reset_n,
  input  wire logic                   clk_en,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [15:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic                        pready,
  output logic [31:0]                 prdata,
  output logic                        pslverr,
  // receive defects per channel
  input  wire logic [7:0]             rx_fas_lost,
  input  wire logic [7:0]             rx_crc_mf_lost,
  input  wire logic [7:0]             rx_cas_mf_lost,
  // receive control per channel
  output logic [7:0]                  frame_loss_defect,
  output logic [7:0]                  frame_search_req,
  output logic [7:0]                  align_algo_sel,
  // transmit stream per channel
  input  wire eagc_pkg::eagc_tx_in_t  tx_in  [eagc_pkg::CHANNELS],
  output eagc_pkg::eagc_tx_out_t      tx_out [eagc_pkg::CHANNELS],
  // interrupt
  output logic                        irq
);

  localparam int NCH = eagc_pkg::CHANNELS;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  logic [7:0]  agc_r      [NCH];
  logic [7:0]  align_r;
  logic [1:0]  sts_r      [NCH];
  logic [1:0]  mask_r     [NCH];
  logic        pready_r;
  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic        irq_r;

  wire  [3:0]  ch_sel     = paddr[15:12];
  wire  [11:0] ofs        = paddr[11:0];
  wire  [2:0]  ch_idx     = ch_sel[2:0];
  wire         ch_ok      = (ch_sel < 4'(NCH));
  wire         hit_agc    = ch_ok && (ofs == eagc_pkg::OFS_AGC);
  wire         hit_align  = ch_ok && (ofs == eagc_pkg::OFS_ALIGN);
  wire         hit_sts    = ch_ok && (ofs == eagc_pkg::OFS_IRQ_STS);
  wire         hit_mask   = ch_ok && (ofs == eagc_pkg::OFS_IRQ_MASK);
  wire         hit_state  = ch_ok && (ofs == eagc_pkg::OFS_STATE);
  wire         hit_any    = hit_agc || hit_align || hit_sts || hit_mask || hit_state;
  wire         setup      = psel && !penable && !pready_r;
  wire         wr_take    = psel && penable && pready_r && pwrite && hit_any;

  wire  [3:0]  state_word = {rx_cas_mf_lost[ch_idx], rx_crc_mf_lost[ch_idx],
                             rx_fas_lost[ch_idx], frame_loss_defect[ch_idx]};

  wire  [31:0] rd_word    = hit_agc   ? {24'h000000, agc_r[ch_idx]} :
                            hit_align ? {31'h00000000, align_r[ch_idx]} :
                            hit_sts   ? {30'h00000000, sts_r[ch_idx]} :
                            hit_mask  ? {30'h00000000, mask_r[ch_idx]} :
                            hit_state ? {28'h0000000, state_word} :
                            32'h00000000;

  // answer one cycle after setup, so pready rises in the first access cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h00000000;
      pslverr_r <= 1'b0;
    end else if (clk_en) begin
      pready_r  <= setup;
      prdata_r  <= (setup && !pwrite) ? rd_word : 32'h00000000;
      pslverr_r <= setup && !hit_any;
    end
  end

  assign pready  = pready_r;
  assign prdata  = prdata_r;
  assign pslverr = pslverr_r;

  // ****************************************************************
  // per channel logic
  // ****************************************************************
  logic [7:0] fl_r;
  logic [7:0] fs_r;
  logic [7:0] irq_hit;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire wr_ch = wr_take && (ch_idx == 3'(g));

      eagc_chan #(
        .CRC_LOSS_CYC (CRC_LOSS_CYC)
      ) u_chan (
        .mclk         (mclk),
        .reset_n      (reset_n),
        .clk_en       (clk_en),
        .wr_agc       (wr_ch && hit_agc),
        .wr_align     (wr_ch && hit_align),
        .wr_sts       (wr_ch && hit_sts),
        .wr_mask      (wr_ch && hit_mask),
        .pwdata       (pwdata),
        .fas_lost     (rx_fas_lost[g]),
        .crc_mf_lost  (rx_crc_mf_lost[g]),
        .cas_mf_lost  (rx_cas_mf_lost[g]),
        .tx_in        (tx_in[g]),
        .tx_out       (tx_out[g]),
        .agc          (agc_r[g]),
        .align        (align_r[g]),
        .sts          (sts_r[g]),
        .mask         (mask_r[g]),
        .frame_loss   (fl_r[g]),
        .search_req   (fs_r[g]),
        .irq_hit      (irq_hit[g])
      );
    end
  endgenerate

  // ****************************************************************
  // outputs
  // ****************************************************************
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irq_r <= 1'b0;
    end else if (clk_en) begin
      irq_r <= |irq_hit;
    end
  end

  // algorithm select itself is a register, so it leaves straight from flops
  assign align_algo_sel    = align_r;
  assign frame_loss_defect = fl_r;
  assign frame_search_req  = fs_r;
  assign irq               = irq_r;

endmodule
